// ### core/fbp_port.sv
/*
 * Five-pin bidirectional I/O port with AHB-Lite register access.
 * Assumes a single AHB-Lite master, hclk at 100 MHz, hresetn asynchronous.
 */
// Notes on behaviour
// - Five bidirectional pins, each with own direction bit and latch bit.
// - Direction bit one makes the pin an input, driver released.
// - Direction bit zero drives the output latch value onto the pin.
// - Data reads return sampled pin levels; writes go to the latch.
// - Writes are not merged with pins: sampled pins are masked off, written bits go to the latch.
// - Fifth pin feeds timer clock input and only pulls low as output.
// - Analog config selects digital or analog per low pin.
// - After reset, low four pins are analog and read zero.
// - Direction mask still applies to low pins in analog mode.
// - Low pin output in analog mode drives its latch value.
// - An enabled sharing peripheral takes priority over the fifth pin; the low four pins are unaffected.
// - Any reset returns the direction mask to all ones.
`timescale 1ns/100ps
module fbp_port (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire fbp_pkg::fbp_pins_t  pin_in,
   output fbp_pkg::fbp_pins_t       pin_out,
   output fbp_pkg::fbp_pins_t       pin_oe,
   output logic                     timer_zero_clock_in
);
   import fbp_pkg::*;

   fbp_cfg_if cfg ();

   fbp_pins_t                first_io_port_data_r;
   fbp_pins_t                direction_mask_first_port_r;
   logic [FBP_ACFG_W-1:0]    analog_config_register_one_r;
   logic                     periph_en_r;
   logic                     wr_pend_r;
   logic [11:0]              wr_addr_r;
   logic [31:0]              hrdata_r;
   logic                     take;

   // Analog select per low pin from the config code.
   function automatic logic [FBP_ANA_PINS-1:0] ana_decode(input logic [FBP_ACFG_W-1:0] code);
      logic [FBP_ANA_PINS-1:0] sel;
      sel = '0;
      if (code[2:1] != FBP_ACFG_ALLDIG[2:1]) begin
         unique case (code)
            3'h0, 3'h1:  sel = 4'hF;
            3'h2, 3'h3:  sel = 4'h3;
            3'h4, 3'h5:  sel = 4'h1;
            default:     sel = 4'h0;
         endcase
      end
      return sel;
   endfunction : ana_decode

   assign take      = hsel && hready && (htrans == FBP_HTRANS_NSEQ || htrans == FBP_HTRANS_SEQ);
   assign hreadyout = 1'b1;
   assign hresp     = FBP_RESP_OKAY;
   assign hrdata    = hrdata_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else begin
         wr_pend_r <= take && hwrite;
         wr_addr_r <= haddr[11:0];
      end
   end

   // Output latch: the sampled pins are masked off and only the written bits are stored.
   // A whole-word write modifies every bit, so a zero can clear a pin read high.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_io_port_data_r <= FBP_LATCH_RST;
      end else if (wr_pend_r && wr_addr_r == FBP_OFS_DATA) begin
         first_io_port_data_r <= (cfg.pin_sync & ~fbp_pins_t'('1))
                                 | fbp_pins_t'(hwdata[FBP_PINS-1:0]);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         direction_mask_first_port_r <= FBP_DIR_RST;
      end else if (wr_pend_r && wr_addr_r == FBP_OFS_DIR) begin
         direction_mask_first_port_r <= hwdata[FBP_PINS-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         analog_config_register_one_r <= FBP_ACFG_RST;
      end else if (wr_pend_r && wr_addr_r == FBP_OFS_ACFG) begin
         analog_config_register_one_r <= hwdata[FBP_ACFG_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         periph_en_r <= 1'b0;
      end else if (wr_pend_r && wr_addr_r == FBP_OFS_PERIPH) begin
         periph_en_r <= hwdata[0];
      end
   end

   // Read data registered at the address phase; unmapped reads zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= '0;
      end else if (take && !hwrite) begin
         hrdata_r <= '0;
         unique case (haddr[11:0])
            FBP_OFS_DATA:   hrdata_r[FBP_PINS-1:0]   <= cfg.pin_sync;
            FBP_OFS_DIR:    hrdata_r[FBP_PINS-1:0]   <= direction_mask_first_port_r;
            FBP_OFS_ACFG:   hrdata_r[FBP_ACFG_W-1:0] <= analog_config_register_one_r;
            FBP_OFS_PERIPH: hrdata_r[0]              <= periph_en_r;
            default:        hrdata_r <= '0;
         endcase
      end
   end

   assign cfg.latch      = first_io_port_data_r;
   assign cfg.dir_mask   = direction_mask_first_port_r;
   assign cfg.analog_sel = ana_decode(analog_config_register_one_r);
   assign cfg.periph_en  = periph_en_r;

   fbp_pin_ctrl u_pins (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .pin_in              (pin_in),
      .pin_out             (pin_out),
      .pin_oe              (pin_oe),
      .timer_zero_clock_in (timer_zero_clock_in),
      .cfg                 (cfg.pins)
   );
endmodule : fbp_port

// ### pkg/fbp_pkg.sv
/*
 * Package for the five-pin bidirectional I/O port: register byte offsets,
 * field layouts, widths and reset values.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package fbp_pkg;
   localparam int          FBP_PINS        = 5;
   localparam int          FBP_ANA_PINS    = 4;
   localparam int          FBP_OD_PIN      = 4;
   localparam int          FBP_ACFG_W      = 3;
   localparam logic [11:0] FBP_OFS_DATA    = 12'h000;
   localparam logic [11:0] FBP_OFS_DIR     = 12'h004;
   localparam logic [11:0] FBP_OFS_ACFG    = 12'h008;
   localparam logic [11:0] FBP_OFS_PERIPH  = 12'h00C;
   localparam logic [4:0]  FBP_DIR_RST     = 5'h1F;
   localparam logic [4:0]  FBP_LATCH_RST   = 5'h00;
   localparam logic [2:0]  FBP_ACFG_RST    = 3'h0;
   localparam logic [2:0]  FBP_ACFG_ALLDIG = 3'h6;
   localparam logic [1:0]  FBP_HTRANS_NSEQ = 2'h2;
   localparam logic [1:0]  FBP_HTRANS_SEQ  = 2'h3;
   localparam logic        FBP_RESP_OKAY   = 1'b0;
   typedef logic [FBP_PINS-1:0] fbp_pins_t;
endpackage : fbp_pkg

// ### pkg/fbp_cfg_if.sv
/*
 * Interface carrying the port configuration from the register file to the
 * pin logic.
 * Assumes both ends run on hclk.
 */
`timescale 1ns/100ps
interface fbp_cfg_if;
   import fbp_pkg::*;
   fbp_pins_t              latch;
   fbp_pins_t              dir_mask;
   logic [FBP_ANA_PINS-1:0] analog_sel;
   logic                    periph_en;
   fbp_pins_t              pin_sync;
   modport regs (output latch, output dir_mask, output analog_sel, output periph_en, input pin_sync);
   modport pins (input latch, input dir_mask, input analog_sel, input periph_en, output pin_sync);
endinterface : fbp_cfg_if

// ### core/fbp_pin_ctrl.sv
/*
 * Pin driver and sampler for the five-pin port.
 * Assumes pin inputs synchronous to hclk; the pad resolves level from enables.
 */
`timescale 1ns/100ps
module fbp_pin_ctrl (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire fbp_pkg::fbp_pins_t pin_in,
   output fbp_pkg::fbp_pins_t pin_out,
   output fbp_pkg::fbp_pins_t pin_oe,
   output logic              timer_zero_clock_in,
   fbp_cfg_if.pins           cfg
);
   import fbp_pkg::*;

   fbp_pins_t samp_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         samp_r <= FBP_LATCH_RST;
      end else begin
         samp_r <= pin_in;
      end
   end

   // Analog pins read as zero digitally.
   always_comb begin
      cfg.pin_sync = samp_r;
      for (int i = 0; i < FBP_ANA_PINS; i++) begin
         if (cfg.analog_sel[i]) begin
            cfg.pin_sync[i] = 1'b0;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < FBP_PINS; i++) begin
         pin_oe[i]  = !cfg.dir_mask[i];
         pin_out[i] = cfg.latch[i];
      end
      // Open-drain: only drive while pulling low.
      pin_oe[FBP_OD_PIN]  = !cfg.dir_mask[FBP_OD_PIN] && !cfg.latch[FBP_OD_PIN];
      pin_out[FBP_OD_PIN] = 1'b0;
      if (cfg.periph_en) begin
         pin_oe[FBP_OD_PIN] = 1'b0;
      end
   end

   assign timer_zero_clock_in = samp_r[FBP_OD_PIN];
endmodule : fbp_pin_ctrl

// ### bench/fbp_port_checker.sv
/* Port checker for fbp_port.
   Assumes one AHB-Lite master and pins settled by hclk. */
`timescale 1ns/100ps
module fbp_port_checker (
   input wire logic               hclk,
   input wire logic               hresetn,
   input wire logic               hsel,
   input wire logic [31:0]        haddr,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic [31:0]        hwdata,
   input wire logic               hready,
   input wire logic [31:0]        hrdata,
   input wire logic               hreadyout,
   input wire logic               hresp,
   input wire fbp_pkg::fbp_pins_t pin_in,
   input wire fbp_pkg::fbp_pins_t pin_out,
   input wire fbp_pkg::fbp_pins_t pin_oe,
   input wire logic               timer_zero_clock_in
);
   import fbp_pkg::*;
   logic dir_wr_r;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) dir_wr_r <= 1'b0;
      else dir_wr_r <= hsel & hready & htrans[1] & hwrite & (haddr[11:0] == FBP_OFS_DIR);
   end
   property p_od_low; pin_out[4] == 1'b0; endproperty
   a_od_low: assert property (p_od_low) else $error("fifth pin driven high");
   property p_tclk; $past(hresetn) |-> timer_zero_clock_in == $past(pin_in[4]); endproperty
   a_tclk: assert property (p_tclk) else $error("timer clock not following pin");
   property p_dir_wr; dir_wr_r |=> pin_oe[3:0] == ~$past(hwdata[3:0]); endproperty
   a_dir_wr: assert property (p_dir_wr) else $error("enables not set by mask");
   property p_oe_cause; $changed(pin_oe[3:0]) |-> $past(dir_wr_r); endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("enable changed without write");
   property p_rst_oe; $rose(hresetn) |-> pin_oe == 5'h00; endproperty
   a_rst_oe: assert property (p_rst_oe) else $error("pin driven after reset");
   property p_rst_rd; $rose(hresetn) |-> hrdata == 32'h0; endproperty
   a_rst_rd: assert property (p_rst_rd) else $error("read data not clear");
   property p_ready; hreadyout == 1'b1; endproperty
   a_ready: assert property (p_ready) else $error("wait state seen");
   property p_okay; hresp == FBP_RESP_OKAY; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   c_dir: cover property (dir_wr_r);
   c_od: cover property (pin_oe[4]);
   c_tclk: cover property ($rose(timer_zero_clock_in));
endmodule : fbp_port_checker
bind fbp_port fbp_port_checker fbp_port_checker_inst (.*);

// ### bench/fbp_board.sv
/* Board model on the port pins.
   Assumes a pull-up on the fifth pin and drivers on the rest. */
`timescale 1ns/100ps
module fbp_board (
   input wire fbp_pkg::fbp_pins_t pin_out,
   input wire fbp_pkg::fbp_pins_t pin_oe,
   input wire fbp_pkg::fbp_pins_t ext_drv,
   output fbp_pkg::fbp_pins_t     pin_in
);
   import fbp_pkg::*;
   assign pin_in[3:0] = (pin_oe[3:0] & pin_out[3:0]) | (~pin_oe[3:0] & ext_drv[3:0]);
   // The fifth pin is wired low by either party, else pulled up.
   assign pin_in[4] = ext_drv[4] & ~(pin_oe[4] & ~pin_out[4]);
endmodule : fbp_board

// ### bench/tb.sv
/* Testbench for fbp_port.
   Assumes a board model on the pins and one bus master. */
`timescale 1ns/100ps
module tb;
   import fbp_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic        hreadyout, hresp, tclk;
   fbp_pins_t   pin_in, pin_out, pin_oe, ext_drv = 5'h1F;
   int          n_mismatch = 0, compares = 0, cyc = 0;
   always #5 hclk = ~hclk;
   fbp_port fbp_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .timer_zero_clock_in(tclk));
   fbp_board fbp_board_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv), .pin_in(pin_in));
   task report_and_stop;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= FBP_HTRANS_NSEQ;
      hwrite <= wr;
      haddr <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(0, FBP_OFS_DATA, 0); chk(q, 32'h10);
      xfer(0, FBP_OFS_DIR, 0); chk(q, {27'h0, FBP_DIR_RST});
      xfer(0, FBP_OFS_ACFG, 0); chk(q, 32'h0);
      xfer(1, FBP_OFS_ACFG, {29'h0, FBP_ACFG_ALLDIG});
      ext_drv <= 5'h0A;
      xfer(0, FBP_OFS_DATA, 0); chk(q, 32'h0A);
      xfer(1, FBP_OFS_DATA, 32'h15);
      @(posedge hclk); chk(pin_oe, 5'h00);
      xfer(1, FBP_OFS_DIR, 32'h0);
      @(posedge hclk); chk({pin_oe, pin_out}, 10'h1E5);
      xfer(0, FBP_OFS_DATA, 0); chk(q, 32'h05);
      chk(tclk, 1'b0);
      ext_drv <= 5'h1F;
      xfer(1, FBP_OFS_DATA, 32'h05);
      @(posedge hclk); chk({pin_oe, pin_out}, 10'h3E5);
      xfer(0, FBP_OFS_DATA, 0); chk(q, 32'h05);
      xfer(1, FBP_OFS_PERIPH, 32'h1);
      repeat (3) @(posedge hclk);
      chk(pin_oe, 5'h0F);
      chk(tclk, 1'b1);
      xfer(1, FBP_OFS_ACFG, 32'h0);
      @(posedge hclk); chk(pin_oe, 5'h0F);
      xfer(0, FBP_OFS_DATA, 0); chk(q, 32'h10);
      xfer(1, FBP_OFS_DIR, 32'h1F);
      xfer(0, 12'h010, 0); chk(q, 32'h0);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(0, FBP_OFS_DIR, 0); chk(q, 32'h1F);
      chk(pin_oe, 5'h00);
      report_and_stop();
   end
endmodule : tb
